// [hdl/ddrlt_pkg.sv]
/*
  constants for the ddr lane timing and termination block.
  assumes a 32-bit register port and a 100 MHz controller clock.
*/
package ddrlt_pkg;
  localparam int          NL        = 2;
  localparam int          AW        = 12;
  localparam int          DW        = 32;
  // register byte addresses
  localparam logic [11:0] A_DLY0    = 12'h300;
  localparam logic [11:0] A_DLY1    = 12'h304;
  localparam logic [11:0] A_TERM0   = 12'h320;
  localparam logic [11:0] A_TERM1   = 12'h324;
  localparam logic [31:0] DLY_RST   = 32'h0000_0000;
  localparam logic [31:0] TERM_RST  = 32'h07C0_0000;
  // delay word fields
  localparam int          B_DEGL    = 28;
  localparam int          B_AUTO    = 27;
  localparam int          F_FIX     = 24;
  localparam int          B_LVL     = 21;
  localparam int          B_XWR     = 19;
  localparam int          B_EARLY   = 18;
  localparam int          B_HALF    = 17;
  localparam int          B_CAS     = 16;
  localparam int          F_QS_S    = 12;
  localparam int          F_QS_E    = 8;
  localparam int          F_WD_S    = 4;
  localparam int          F_WD_E    = 0;
  // termination word fields
  localparam int          F_ON      = 28;
  localparam int          F_OFF     = 24;
  localparam int          B_TLEV    = 23;
  localparam int          B_TEN     = 22;
  localparam int          F_CLOSE   = 8;
  localparam int          F_OPEN    = 0;
  // four beats of the read burst, in half cycles
  localparam logic [6:0]  PRE_HALF  = 7'h04;
  localparam logic [4:0]  WMAX      = 5'h1F;
  localparam logic [5:0]  RMAX      = 6'h3F;
endpackage

// [hdl/ddrlt_lane_ctrl.sv]
/*
  per-lane write strobe and data windows, read sampling window, read
  completion and pad termination for a ddr phy.
  assumes commands come from logic on clk; clk_wr, dqs and dq are pins.
*/
// Strobed register access was decided locally.
// Summary of operation
// R01: per lane, a bit routes the read gate through the loopback delay
// R02: auto bit picks fifo-valid completion, else the fixed delay
// R03: three-bit field gives completion delay in clk cycles
// R04: in leveling mode the sampled dq level shows in status bit
// R05: software keeps the data-valid level bit at zero
// R06: extra write bit delays write data one more cycle
// R07: early bit samples read strobe on the other clk_wr edge
// R08: half bit asks half-cycle shift of write data and strobe
// R09: cas bit asks a half-cycle cas latency component
// R10: four-bit field sets when write strobe drive starts
// R11: for ddr3 software starts the strobe one cycle earlier
// R12: four-bit field sets when write strobe drive stops
// R13: three-bit field sets when write data turns valid
// R14: three-bit field sets when write data stops being valid
// R15: dynamic termination is on only during a read
// R16: turn-on in half cycles, counted after the four read beats
// R17: four-bit field sets termination turn-off time
// R18: level bit gives termination polarity, active one
// R19: enable picks dynamic, else level bit selects always on or never
// R20: software keeps termination test fields at zero
// R21: one-hot field sets sampling window close
// R22: one-hot field sets sampling window open
// R23: every lane owns its own delay and termination words
module ddrlt_lane_ctrl
  import ddrlt_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // register port
  input  wire logic [ddrlt_pkg::AW-1:0]  reg_addr,
  input  wire logic [ddrlt_pkg::DW-1:0]  reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ddrlt_pkg::DW-1:0]  reg_rdata,
  // commands from the scheduler
  input  wire logic                      wr_cmd,
  input  wire logic                      rd_cmd,
  input  wire logic                      lvl_mode,
  input  wire logic [ddrlt_pkg::NL-1:0]  rd_fifo_valid,
  // pins
  input  wire logic                      clk_wr,
  input  wire logic [ddrlt_pkg::NL-1:0]  dqs_in,
  input  wire logic [ddrlt_pkg::NL-1:0]  dq_in,
  // lane controls
  output logic      [ddrlt_pkg::NL-1:0]  dqs_oe,
  output logic      [ddrlt_pkg::NL-1:0]  dq_oe,
  output logic      [ddrlt_pkg::NL-1:0]  odt,
  output logic      [ddrlt_pkg::NL-1:0]  rd_gate,
  output logic      [ddrlt_pkg::NL-1:0]  rd_done,
  output logic      [ddrlt_pkg::NL-1:0]  dqs_cap,
  output logic      [ddrlt_pkg::NL-1:0]  wr_half,
  output logic      [ddrlt_pkg::NL-1:0]  cas_half
);
  import ddrlt_pkg::*;

  typedef struct packed {
    logic [NL-1:0][31:0] dly;
    logic [NL-1:0][31:0] term;
    logic [31:0]         rdata;
    logic [1:0]          wr_s;
    logic                wr_d;
    logic [NL-1:0][1:0]  dqs_s;
    logic [NL-1:0][1:0]  dq_s;
    logic                wact;
    logic [4:0]          wcnt;
    logic                ract;
    logic [5:0]          rcnt;
    logic [NL-1:0]       graw;
    logic [NL-1:0]       gate;
    logic [NL-1:0]       pend;
    logic [NL-1:0]       done;
    logic [NL-1:0]       lvl;
    logic [NL-1:0]       cap;
    logic [NL-1:0]       qs_oe;
    logic [NL-1:0]       d_oe;
    logic [NL-1:0]       odt;
  } ddrlt_state_t;

  ddrlt_state_t r, n;

  // index of the lowest set bit; zero field gives zero
  function automatic logic [2:0] ddrlt_idx(input logic [7:0] f);
    logic [2:0] k;
    k = 3'h0;
    for (int b = 7; b >= 0; b--)
    begin
      if (f[b])
        k = 3'(b);
    end
    return k;
  endfunction

  logic [5:0] opn    [NL];
  logic [5:0] cls    [NL];
  logic [6:0] on_h   [NL];
  logic [6:0] off_h  [NL];
  logic [6:0] rhalf;
  logic       wrise;
  logic       wfall;

  always_comb
  begin
    n = r;
    n.rdata = 32'h0000_0000;
    n.done = '0;
    n.wr_s = {r.wr_s[0], clk_wr};
    n.wr_d = r.wr_s[1];
    wrise = r.wr_s[1] & ~r.wr_d;
    wfall = ~r.wr_s[1] & r.wr_d;
    rhalf = {r.rcnt, 1'b0};
    // command counters, a new command restarts its window
    if (wr_cmd)
    begin
      n.wact = 1'b1;
      n.wcnt = 5'h00;
    end
    else if (r.wact)
    begin
      n.wcnt = r.wcnt + 5'h01;
      n.wact = (r.wcnt != WMAX);
    end
    if (rd_cmd)
    begin
      n.ract = 1'b1;
      n.rcnt = 6'h00;
      n.pend = '0;
    end
    else if (r.ract)
    begin
      n.rcnt = r.rcnt + 6'h01;
      n.ract = (r.rcnt != RMAX);
    end
    for (int l = 0; l < NL; l++)
    begin
      n.dqs_s[l] = {r.dqs_s[l][0], dqs_in[l]};
      n.dq_s[l] = {r.dq_s[l][0], dq_in[l]};
      // strobe window, ddr3 preamble is the caller's start choice
      n.qs_oe[l] = r.wact && (r.wcnt >= {1'b0, r.dly[l][F_QS_S+:4]}) // see R10 R11
                   && (r.wcnt <= {1'b0, r.dly[l][F_QS_E+:4]}); // see R12
      n.d_oe[l] = r.wact // see R13 R14
                  && (r.wcnt >= {2'b00, r.dly[l][F_WD_S+:3]} + {4'h0, r.dly[l][B_XWR]}) // see R06
                  && (r.wcnt <= {2'b00, r.dly[l][F_WD_E+:3]} + {4'h0, r.dly[l][B_XWR]});
      // sampling window in clk cycles after the read command
      opn[l] = {3'h0, ddrlt_idx(r.term[l][F_OPEN+:8])}; // see R22
      cls[l] = opn[l] + {3'h0, ddrlt_idx({4'h0, r.term[l][F_CLOSE+:4]})} + 6'h01; // see R21
      n.graw[l] = r.ract && (r.rcnt >= opn[l]) && (r.rcnt < cls[l]);
      // loopback path costs one cycle of gate latency
      n.gate[l] = r.dly[l][B_DEGL] ? r.graw[l] : n.graw[l]; // see R01
      if ((r.dly[l][B_EARLY] ? wrise : wfall) && r.gate[l]) // see R07
        n.cap[l] = r.dqs_s[l][1];
      // completion of read data return sampling
      if (r.ract && r.rcnt == cls[l])
        n.pend[l] = r.dly[l][B_AUTO];
      if (r.pend[l] && rd_fifo_valid[l]) // see R02
      begin
        n.done[l] = 1'b1;
        n.pend[l] = 1'b0;
      end
      if (!r.dly[l][B_AUTO] && r.ract
          && r.rcnt == cls[l] + {3'h0, r.dly[l][F_FIX+:3]}) // see R02 R03
        n.done[l] = 1'b1;
      if (lvl_mode)
        n.lvl[l] = r.dq_s[l][1]; // see R04
      // termination window in half cycles
      on_h[l] = PRE_HALF + {3'h0, r.term[l][F_ON+:4]}; // see R16
      off_h[l] = on_h[l] + {3'h0, r.term[l][F_OFF+:4]}; // see R17
      if (r.term[l][B_TEN]) // see R19
        n.odt[l] = (r.ract && rhalf >= on_h[l] && rhalf < off_h[l]) // see R15
                   ^ ~r.term[l][B_TLEV]; // see R18
      else
        n.odt[l] = ~r.term[l][B_TLEV]; // see R19
    end
    // register port, words are stored whole including test fields
    if (reg_wr)
    begin
      case (reg_addr)
        A_DLY0:  n.dly[0] = reg_wdata; // see R23
        A_DLY1:  n.dly[1] = reg_wdata;
        A_TERM0: n.term[0] = reg_wdata;
        A_TERM1: n.term[1] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        A_DLY0:  n.rdata = {r.dly[0][31:22], r.lvl[0], r.dly[0][20:0]}; // see R04
        A_DLY1:  n.rdata = {r.dly[1][31:22], r.lvl[1], r.dly[1][20:0]};
        A_TERM0: n.rdata = r.term[0];
        A_TERM1: n.rdata = r.term[1];
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (!resetn)
    begin
      n = '0;
      n.dly = {NL{DLY_RST}};
      n.term = {NL{TERM_RST}};
    end
  end

  always_ff @(posedge clk)
    r <= n;

  always_comb
  begin
    reg_rdata = r.rdata;
    dqs_oe = r.qs_oe;
    dq_oe = r.d_oe;
    odt = r.odt;
    rd_gate = r.gate;
    rd_done = r.done;
    dqs_cap = r.cap;
    for (int l = 0; l < NL; l++)
    begin
      wr_half[l] = r.dly[l][B_HALF]; // see R08
      cas_half[l] = r.dly[l][B_CAS]; // see R09
    end
  end

  // checks on lane 0, plus register readback of lane 1
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_wr_start;
    wr_cmd ##1 !wr_cmd;
  endsequence
  sequence s_rd_start;
    rd_cmd ##1 !rd_cmd;
  endsequence

  a_qs_start_time: assert property ( // see R10
    wr_cmd && !r.wact && r.dly[0][F_QS_S+:4] == 4'h2 && r.dly[0][F_QS_E+:4] >= 4'h2
      && !reg_wr |=> !dqs_oe[0] ##1 !dqs_oe[0] ##1 !dqs_oe[0]
      ##1 (dqs_oe[0] || $past(wr_cmd, 2) || $past(wr_cmd, 3) || $past(reg_wr, 2)
      || $past(reg_wr, 3)))
    else $error("write strobe start is wrong");
  a_qs_end_time: assert property ( // see R12
    r.wact && r.wcnt == {1'b0, r.dly[0][F_QS_E+:4]} + 5'h01 && !wr_cmd |=> !dqs_oe[0])
    else $error("write strobe still driven after end");
  a_wd_extra_dly: assert property ( // see R06 R13
    r.wact && r.dly[0][B_XWR] && r.wcnt == {2'b00, r.dly[0][F_WD_S+:3]}
      && r.dly[0][F_WD_E+:3] >= r.dly[0][F_WD_S+:3]
      && !wr_cmd && !reg_wr |=> !dq_oe[0] ##1 (dq_oe[0] || wr_cmd || reg_wr))
    else $error("write data extra cycle missing");
  a_odt_static: assert property ( // see R19
    !r.term[0][B_TEN] && !reg_wr |=> odt[0] == ~$past(r.term[0][B_TLEV]))
    else $error("static termination level wrong");
  a_odt_idle_off: assert property ( // see R15 R18
    r.term[0][B_TEN] && r.term[0][B_TLEV] && !r.ract && !rd_cmd && !reg_wr |=> !odt[0])
    else $error("termination on outside a read");
  a_done_fixed: assert property ( // see R03
    s_rd_start ##0 (!r.dly[0][B_AUTO] && r.term[0][15:0] == 16'h0101
      && r.dly[0][F_FIX+:3] == 3'h2 && !reg_wr) [*1] |-> ##4 rd_done[0] || $past(rd_cmd)
      || $past(rd_cmd, 2) || $past(rd_cmd, 3) || $past(reg_wr) || $past(reg_wr, 2)
      || $past(reg_wr, 3))
    else $error("fixed completion delay wrong");
  a_done_auto: assert property ( // see R02
    rd_done[0] |-> $past(r.dly[0][B_AUTO]) ? $past(rd_fifo_valid[0]) : 1'b1)
    else $error("auto completion without fifo valid");
  a_rdata_word: assert property ( // see R23
    reg_rd && reg_addr == A_TERM1 |=> reg_rdata == $past(r.term[1]))
    else $error("read data not the addressed word");
  a_lvl_status: assert property ( // see R04
    lvl_mode ##1 reg_rd && reg_addr == A_DLY0 |=> reg_rdata[B_LVL] == $past(r.dq_s[0][1], 2))
    else $error("leveling status not the sampled level");

  // capture only moves inside the gate and on the chosen clk_wr edge
  a_cap_idle_hold: assert property ( // see R07
    !rd_gate[0] |=> $stable(dqs_cap[0]))
    else $error("strobe captured outside the gate");

  a_cap_rise_only: assert property ( // see R07
    rd_gate[0] && r.dly[0][B_EARLY] && !(r.wr_s[1] && !r.wr_d) |=> $stable(dqs_cap[0]))
    else $error("early capture off the rising edge");

  a_cap_fall_only: assert property ( // see R07
    rd_gate[0] && !r.dly[0][B_EARLY] && !(!r.wr_s[1] && r.wr_d) |=> $stable(dqs_cap[0]))
    else $error("late capture off the falling edge");

  // the loopback path adds exactly one cycle to the gate
  a_gate_loopback: assert property ( // see R01
    r.dly[0][B_DEGL] |=> rd_gate[0] == $past(r.graw[0]))
    else $error("loopback gate not one cycle late");

  a_gate_direct: assert property ( // see R01
    !r.dly[0][B_DEGL] |=> rd_gate[0] == r.graw[0])
    else $error("direct gate delayed");

  a_gate_needs_read: assert property ( // see R22
    !r.ract |=> !r.graw[0])
    else $error("sampling window open without a read");

  // dynamic termination edges, counted in half cycles after the beats
  a_odt_dyn_on: assert property ( // see R15 R16
    r.term[0][B_TEN] && r.term[0][B_TLEV] && r.ract && r.term[0][F_OFF+:4] != 4'h0
      && {r.rcnt, 1'b0} == PRE_HALF + {3'h0, r.term[0][F_ON+:4]} |=> odt[0])
    else $error("termination did not turn on");

  a_odt_dyn_off: assert property ( // see R17
    r.term[0][B_TEN] && r.term[0][B_TLEV] && r.ract && {r.rcnt, 1'b0} >= PRE_HALF
      + {3'h0, r.term[0][F_ON+:4]} + {3'h0, r.term[0][F_OFF+:4]} |=> !odt[0])
    else $error("termination did not turn off");

  a_odt_polarity: assert property ( // see R18
    r.term[0][B_TEN] && !r.term[0][B_TLEV] && !r.ract |=> odt[0])
    else $error("inverted termination level ignored");

  // auto completion follows the first fifo valid while pending
  a_done_pend: assert property ( // see R02
    r.pend[0] && rd_fifo_valid[0] |=> rd_done[0] && !r.pend[0])
    else $error("pending completion not taken");

  a_wd_stop: assert property ( // see R14
    r.wact && r.wcnt > {2'b00, r.dly[0][F_WD_E+:3]} + {4'h0, r.dly[0][B_XWR]} |=> !dq_oe[0])
    else $error("write data valid after end");

  a_wr_needs_cmd: assert property ( // see R10 R13
    !r.wact |=> !dqs_oe[0] && !dq_oe[0])
    else $error("write window without a command");

  a_wcnt_restart: assert property ( // see R10
    wr_cmd |=> r.wact && r.wcnt == 5'h00)
    else $error("write counter not restarted");

  // level is frozen outside leveling so status reads stay meaningful
  a_lvl_hold: assert property ( // see R04
    !lvl_mode |=> $stable(r.lvl[0]))
    else $error("leveling status moved outside leveling");

  a_rdata_lane1: assert property ( // see R23
    reg_rd && reg_addr == A_DLY1 |=> reg_rdata[31:22] == $past(r.dly[1][31:22]))
    else $error("lane one delay word not returned");
endmodule // ddrlt_lane_ctrl

// [verif/ddrlt_sdram_model.sv]
/*
  data-side model of the memory devices facing one pair of lanes.
  assumes clk is the controller clock and lvl_v is set by the bench.
*/
module ddrlt_sdram_model
  import ddrlt_pkg::*;
(
  // clock and leveling control
  input  wire logic                      clk,
  input  wire logic                      lvl_mode,
  input  wire logic                      lvl_v,
  // pins toward the lanes
  output logic      [ddrlt_pkg::NL-1:0]  dqs_in,
  output logic      [ddrlt_pkg::NL-1:0]  dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    dqs_in = '0;
    dq_in  = '1;
  end
  // idle data toggles so a stale level can never pass for a sampled one
  always @(posedge clk)
  begin
    dqs_in <= ~dqs_in;
    dq_in  <= lvl_mode ? {NL{lvl_v}} : ~dq_in;
  end
endmodule // ddrlt_sdram_model

// [verif/ddrlt_lane_ctrl_bench.sv]
/*
  self-checking bench for the lane block: registers and lane 0 windows.
  assumes the register port and timing walks of the block's hand-over.
*/
`define chk(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module ddrlt_lane_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ddrlt_pkg::*;
  logic          clk = 0, resetn = 0, clk_wr = 0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0, reg_rdata, ev, dl;
  logic          reg_wr = 0, reg_rd = 0, wr_cmd = 0, rd_cmd = 0;
  logic          lvl_mode = 0, lvl_v = 0, rd_q = 0, tr_go = 0;
  logic [NL-1:0] rd_fifo_valid = '0, dqs_in, dq_in, dqs_oe, dq_oe, odt;
  logic [NL-1:0] rd_gate, rd_done, dqs_cap, wr_half, cas_half;
  logic [6:0]    tv;
  logic [DW-1:0] exp_rd[$];
  logic [6:0]    exp_tr[$];
  int            n_fail = 0, checks = 0, cyc = 0, tr_n = 0, seed = 96058;
  wire logic [6:0] obs = {cas_half[0], wr_half[0], odt[0], rd_done[0], rd_gate[0],
                          dq_oe[0], dqs_oe[0]};

  ddrlt_lane_ctrl u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .wr_cmd, .rd_cmd, .lvl_mode, .rd_fifo_valid, .clk_wr, .dqs_in, .dq_in,
    .dqs_oe, .dq_oe, .odt, .rd_gate, .rd_done, .dqs_cap, .wr_half, .cas_half);
  ddrlt_sdram_model u_mem (.clk, .lvl_mode, .lvl_v, .dqs_in, .dq_in);

  initial forever #5 clk = ~clk;
  initial
  begin
    #3;
    forever #40 clk_wr = ~clk_wr;
  end

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1;
    @(posedge clk);
    reg_wr    <= 0;
  endtask

  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1;
    exp_rd.push_back(e);
    @(posedge clk);
    reg_rd   <= 0;
  endtask

  // expected lane 0 outputs in cycle i after the command cycle
  function automatic logic [6:0] ex(int i, logic [31:0] d, t, int o, c);
    int   r;
    logic dy;
    r       = i - 1;
    dy      = (2 * r >= 4 + t[31:28]) && (2 * r < 4 + t[31:28] + t[27:24]);
    ex[0]   = r >= d[15:12] && r <= d[11:8];
    ex[1]   = r >= d[6:4] + d[19] && r <= d[2:0] + d[19];
    ex[2]   = r >= o + d[28] && r < o + c + 1 + d[28];
    ex[3]   = d[27] ? (i == o + c + 6) : (i == o + c + 2 + d[26:24]);
    ex[4]   = t[22] ? dy ^ ~t[23] : ~t[23];
    ex[6:5] = {d[16], d[17]};
  endfunction

  task automatic run(int it);
    logic [31:0] d, t;
    int          o, c;
    o     = {$random(seed)} % 4;
    c     = {$random(seed)} % 3;
    d     = $random(seed) & 32'h170F_FF77;
    d[27] = it[0];
    dl    = d;
    t     = {4'({$random(seed)} % 4), 4'(1 + {$random(seed)} % 4), 2'($random(seed)),
             10'h000, 4'h1 << c, 8'h01 << o};
    if (it == 1)
      d[28] = 1'b1;
    dl = d;
    wr(A_DLY0, d);
    wr(A_DLY1, ~d & 32'h1F0F_FF77);
    wr(A_TERM0, t);
    wr(A_TERM1, {t[27:24], t[31:28], ~t[23:22], t[21:0]});
    rd(A_DLY0, d);
    rd(A_TERM0, t);
    rd(A_DLY1, ~d & 32'h1F0F_FF77);
    rd(A_TERM1, {t[27:24], t[31:28], ~t[23:22], t[21:0]});
    @(posedge clk);
    wr_cmd <= 1;
    rd_cmd <= 1;
    for (int i = 1; i < 20; i++)
      exp_tr.push_back(ex(i, d, t, o, c));
    for (int k = 1; k < 22; k++)
    begin
      @(posedge clk);
      wr_cmd        <= 0;
      rd_cmd        <= 0;
      tr_go         <= k == 1;
      // an early valid before the window must be ignored in both modes
      rd_fifo_valid <= {1'($random(seed)), 1'(k == 1 || k == o + c + 6)};
    end
    $display("test %0d done", it);
  endtask

  task automatic lvl(logic v);
    lvl_v <= v;
    repeat (6) @(posedge clk);
    rd(A_DLY0, {dl[31:22], v, dl[20:0]});
    $display("leveling %0d done", v);
  endtask

  always @(posedge clk)
  begin
    rd_q <= reg_rd;
    if (rd_q)
    begin
      ev = exp_rd.pop_front();
      `chk("reg_rdata", ev, reg_rdata)
    end
    if (tr_n > 0)
    begin
      tv = exp_tr.pop_front();
      `chk("lane0", tv, obs)
    end
    tr_n <= tr_go ? 19 : (tr_n > 0 ? tr_n - 1 : 0);
    cyc  <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    rd(A_TERM0, TERM_RST);
    rd(A_DLY1, DLY_RST);
    wr(12'h308, '1);
    rd(12'h308, '0);
    $display("reset and unmapped done");
    for (int it = 0; it < 8; it++)
      run(it);
    lvl_mode <= 1;
    lvl(1'b1);
    lvl(1'b0);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule // ddrlt_lane_ctrl_bench
